// File: inc/tcbd_pkg.sv
// Constants and types for the taskfile command block decoder.
// Assumes a 10 MHz bridge clock and a 16-byte command block presented whole.
package tcbd_pkg;
    // ---------------------------------------------------------------
    // Register map (AXI4-Lite byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] TCBD_CTRL_ADDR    = 8'h00;
    localparam logic [7:0] TCBD_STATUS_ADDR  = 8'h04;
    localparam logic [7:0] TCBD_ACTION_ADDR  = 8'h08;
    localparam logic [7:0] TCBD_RDATA0_ADDR  = 8'h0c;
    localparam logic [7:0] TCBD_RDATA1_ADDR  = 8'h10;
    localparam logic [7:0] TCBD_CONFIG_ADDR  = 8'h14;
    localparam logic [7:0] TCBD_CFG_SIG_RST  = 8'h00;
    localparam logic [7:0] TCBD_CFG_DEV_RST  = 8'h00;

    // ---------------------------------------------------------------
    // Command block layout
    // ---------------------------------------------------------------
    localparam int          TCBD_CB_BYTES     = 16;
    localparam logic [7:0]  TCBD_SUBCMD       = 8'h24;
    localparam int          TCBD_IDX_SIG      = 0;
    localparam int          TCBD_IDX_SUB      = 1;
    localparam int          TCBD_IDX_ACT      = 2;
    localparam int          TCBD_IDX_RSEL     = 3;
    localparam int          TCBD_IDX_BCNT     = 4;
    localparam int          TCBD_IDX_WDATA    = 5;
    localparam int          TCBD_IDX_DEVHEAD  = 11;
    localparam int          TCBD_DEVHEAD_DEV  = 4;
    localparam int          TCBD_CFG_DEV_BIT  = 5;
    localparam int          TCBD_ACT_IDENT    = 7;
    localparam int          TCBD_ACT_UDMA     = 6;
    localparam int          TCBD_ACT_DEVSRC   = 5;
    localparam int          TCBD_ACT_ERR_HI   = 4;
    localparam int          TCBD_ACT_ERR_LO   = 3;
    localparam int          TCBD_ACT_NOPOLL   = 2;
    localparam int          TCBD_ACT_LATESEL  = 1;
    localparam int          TCBD_ACT_RDONLY   = 0;
    localparam int          TCBD_BSY_BIT      = 7;
    localparam logic [2:0]  TCBD_REG_DEVHEAD  = 3'h6;
    localparam logic [2:0]  TCBD_REG_LAST     = 3'h7;
    localparam logic [1:0]  TCBD_HALT_BOTH    = 2'h0;
    localparam logic [1:0]  TCBD_HALT_DEV     = 2'h1;
    localparam logic [1:0]  TCBD_HALT_PHASE   = 2'h2;

    typedef enum logic [2:0] {
        TCBD_IDLE    = 3'b000,
        TCBD_POLL    = 3'b001,
        TCBD_SELECT  = 3'b010,
        TCBD_ACCESS  = 3'b011,
        TCBD_XFER    = 3'b100,
        TCBD_DONE    = 3'b101
    } tcbd_state_t;
endpackage : tcbd_pkg

// File: logic/tcbd_sync2.sv
// Two-flop synchroniser for one level input.
// Assumes the input is asynchronous to aclk.
`timescale 1ns/1ps
`default_nettype none
module tcbd_sync2 (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic din,
    output logic      dout
);
    logic meta_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= 1'b0;
            dout   <= 1'b0;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule // tcbd_sync2
`default_nettype wire

// File: logic/tcbd_decoder.sv
// Taskfile command block decoder with AXI4-Lite register access.
// Assumes the transport layer presents a whole 16-byte command block with a
// one-cycle strobe, and a taskfile sequencer port handshaking on aclk.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Signature match marks a taskfile block
// - Bit 7 flags identify data phase
// - Bit 6 picks UDMA, else PIO
// - Bit 5 picks DEV bit source
// - Bits 4:3 choose error halting
// - Bit 2 clear polls BSY first
// - Bit 1 places device select late
// - Bit 0 reads selected registers only
// - Read bytes ordered alternate_status_register through status
// - Register accesses ascend zero to seven
// - Other wrapper fields handled normally
// - Select bits map registers 3F6h..1F7h
// - Only zero or power-of-two block counts accepted
module tcbd_decoder
    import tcbd_pkg::*;
(
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // AXI4-Lite slave
    input  wire logic [7:0]   s_axi_awaddr,
    input  wire logic         s_axi_awvalid,
    output logic              s_axi_awready,
    input  wire logic [31:0]  s_axi_wdata,
    input  wire logic [3:0]   s_axi_wstrb,
    input  wire logic         s_axi_wvalid,
    output logic              s_axi_wready,
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  wire logic         s_axi_bready,
    input  wire logic [7:0]   s_axi_araddr,
    input  wire logic         s_axi_arvalid,
    output logic              s_axi_arready,
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  wire logic         s_axi_rready,
    // Command block from transport
    input  wire logic         cb_valid,
    input  wire logic [127:0] cb_bytes,
    output logic              cb_taskfile,
    output logic              cb_ordinary,
    // Taskfile sequencer
    input  wire logic         dev_error,
    input  wire logic         phase_error,
    output logic              tf_req,
    output logic              tf_write,
    output logic [2:0]        tf_reg,
    output logic [7:0]        tf_wdata,
    input  wire logic         tf_ack,
    input  wire logic [7:0]   tf_rdata,
    output logic              xfer_start,
    output logic              xfer_udma,
    output logic              xfer_identify,
    output logic              xfer_halt,
    input  wire logic         xfer_done_async,
    output logic              cmd_pass,
    output logic              cmd_fail
);
    // ---------------------------------------------------------------
    // Registers and state
    // ---------------------------------------------------------------
    tcbd_state_t state_q;
    logic [7:0]  cfg_sig_q, cfg_dev_q;
    logic [7:0]  act_q, rsel_q;
    logic [7:0]  wr_q [0:7];
    logic [7:0]  rd_q [0:7];
    logic [2:0]  idx_q;
    logic        sel_done_q, dev_bit_q;
    logic        aw_q, w_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        xfer_done;

    tcbd_sync2 u_done_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (xfer_done_async),
        .dout    (xfer_done)
    );

    // ---------------------------------------------------------------
    // Block recognition
    // ---------------------------------------------------------------
    logic [7:0] cb [0:15];
    logic       sig_ok, bcnt_ok;
    always_comb begin
        for (int i = 0; i < TCBD_CB_BYTES; i++) begin
            cb[i] = cb_bytes[8*i +: 8];
        end
    end
    assign sig_ok = (cb[TCBD_IDX_SIG] == cfg_sig_q)
                 && (cb[TCBD_IDX_SUB] == TCBD_SUBCMD);
    // Legal counts: zero (256 sectors) or a single set bit
    assign bcnt_ok = (cb[TCBD_IDX_BCNT] & (cb[TCBD_IDX_BCNT] - 8'h01)) == 8'h00;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cb_taskfile <= 1'b0;
            cb_ordinary <= 1'b0;
        end else begin
            cb_taskfile <= cb_valid && sig_ok;
            cb_ordinary <= cb_valid && !sig_ok;
        end
    end

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    logic       cur_sel, halt_now;
    logic [7:0] dev_wdata;
    assign cur_sel   = rsel_q[idx_q];
    assign dev_wdata = {wr_q[TCBD_REG_DEVHEAD][7:TCBD_DEVHEAD_DEV+1], dev_bit_q,
                        wr_q[TCBD_REG_DEVHEAD][TCBD_DEVHEAD_DEV-1:0]};
    always_comb begin
        case (act_q[TCBD_ACT_ERR_HI:TCBD_ACT_ERR_LO])
            TCBD_HALT_BOTH:  halt_now = dev_error || phase_error;
            TCBD_HALT_DEV:   halt_now = dev_error;
            TCBD_HALT_PHASE: halt_now = phase_error;
            default:         halt_now = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q       <= TCBD_IDLE;
            act_q         <= 8'h00;
            rsel_q        <= 8'h00;
            idx_q         <= 3'h0;
            sel_done_q    <= 1'b0;
            dev_bit_q     <= 1'b0;
            tf_req        <= 1'b0;
            tf_write      <= 1'b0;
            tf_reg        <= 3'h0;
            tf_wdata      <= 8'h00;
            xfer_start    <= 1'b0;
            xfer_udma     <= 1'b0;
            xfer_identify <= 1'b0;
            xfer_halt     <= 1'b0;
            cmd_pass      <= 1'b0;
            cmd_fail      <= 1'b0;
            for (int i = 0; i < 8; i++) begin
                wr_q[i] <= 8'h00;
                rd_q[i] <= 8'h00;
            end
        end else begin
            cmd_pass   <= 1'b0;
            cmd_fail   <= 1'b0;
            xfer_start <= 1'b0;
            case (state_q)
                TCBD_IDLE: begin
                    if (cb_valid && sig_ok) begin
                        if (!bcnt_ok) begin
                            cmd_fail <= 1'b1;
                        end else begin
                            act_q      <= cb[TCBD_IDX_ACT];
                            rsel_q     <= cb[TCBD_IDX_RSEL];
                            idx_q      <= 3'h0;
                            sel_done_q <= 1'b0;
                            dev_bit_q  <= cb[TCBD_IDX_ACT][TCBD_ACT_DEVSRC] ?
                                cb[TCBD_IDX_DEVHEAD][TCBD_DEVHEAD_DEV] :
                                cfg_dev_q[TCBD_CFG_DEV_BIT];
                            for (int i = 0; i < 8; i++) begin
                                wr_q[i] <= cb[TCBD_IDX_WDATA + i];
                                rd_q[i] <= 8'h00;
                            end
                            xfer_udma     <= cb[TCBD_IDX_ACT][TCBD_ACT_UDMA];
                            xfer_identify <= cb[TCBD_IDX_ACT][TCBD_ACT_IDENT];
                            xfer_halt     <= 1'b0;
                            tf_reg        <= TCBD_REG_LAST;
                            tf_write      <= 1'b0;
                            tf_req        <= !cb[TCBD_IDX_ACT][TCBD_ACT_NOPOLL];
                            state_q <= cb[TCBD_IDX_ACT][TCBD_ACT_NOPOLL] ?
                                       TCBD_SELECT : TCBD_POLL;
                        end
                    end
                end
                TCBD_POLL: begin
                    // Status read repeats until busy clears
                    if (tf_ack) begin
                        if (!tf_rdata[TCBD_BSY_BIT]) begin
                            tf_req  <= 1'b0;
                            state_q <= TCBD_SELECT;
                        end
                    end
                end
                TCBD_SELECT: begin
                    // Early select before writes, or late select after them
                    if (tf_req) begin
                        if (tf_ack) begin
                            tf_req     <= 1'b0;
                            sel_done_q <= 1'b1;
                            state_q    <= act_q[TCBD_ACT_LATESEL] ? TCBD_XFER : TCBD_ACCESS;
                        end
                    end else if (act_q[TCBD_ACT_RDONLY] ||
                                 (act_q[TCBD_ACT_LATESEL] && !sel_done_q && idx_q == 3'h0
                                  && !tf_write)) begin
                        state_q <= TCBD_ACCESS;
                    end else begin
                        tf_req   <= 1'b1;
                        tf_write <= 1'b1;
                        tf_reg   <= TCBD_REG_DEVHEAD;
                        tf_wdata <= dev_wdata;
                    end
                end
                TCBD_ACCESS: begin
                    if (tf_req) begin
                        if (tf_ack) begin
                            tf_req <= 1'b0;
                            if (!tf_write) rd_q[idx_q] <= tf_rdata;
                            idx_q <= idx_q + 3'h1;
                            if (idx_q == TCBD_REG_LAST) state_q <= TCBD_XFER;
                        end
                    end else if (cur_sel) begin
                        tf_req   <= 1'b1;
                        tf_write <= !act_q[TCBD_ACT_RDONLY];
                        tf_reg   <= idx_q;
                        tf_wdata <= (idx_q == TCBD_REG_DEVHEAD) ? dev_wdata : wr_q[idx_q];
                    end else begin
                        idx_q <= idx_q + 3'h1;
                        if (idx_q == TCBD_REG_LAST) state_q <= TCBD_XFER;
                    end
                end
                TCBD_XFER: begin
                    if (act_q[TCBD_ACT_LATESEL] && !sel_done_q && !act_q[TCBD_ACT_RDONLY]) begin
                        tf_write <= 1'b1;
                        state_q  <= TCBD_SELECT;
                    end else if (act_q[TCBD_ACT_RDONLY]) begin
                        state_q <= TCBD_DONE;
                    end else if (!xfer_start && !xfer_halt) begin
                        xfer_start <= 1'b1;
                        xfer_halt  <= 1'b1;                              // Marks start issued
                    end else if (halt_now) begin
                        cmd_fail  <= 1'b1;
                        xfer_halt <= 1'b1;
                        state_q   <= TCBD_IDLE;
                    end else if (xfer_done) begin
                        state_q <= TCBD_DONE;
                    end
                end
                TCBD_DONE: begin
                    cmd_pass  <= 1'b1;
                    xfer_halt <= 1'b0;
                    state_q   <= TCBD_IDLE;
                end
                default: state_q <= TCBD_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // AXI4-Lite slave
    // ---------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q          <= 1'b0;
            w_q           <= 1'b0;
            awaddr_q      <= 8'h00;
            wdata_q       <= 32'h0000_0000;
            wstrb_q       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
            cfg_sig_q     <= TCBD_CFG_SIG_RST;
            cfg_dev_q     <= TCBD_CFG_DEV_RST;
        end else begin
            s_axi_awready <= !aw_q && s_axi_awvalid && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready  <= !w_q && s_axi_wvalid && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q     <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q     <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (aw_q && w_q && !s_axi_bvalid) begin
                aw_q         <= 1'b0;
                w_q          <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (awaddr_q == TCBD_CONFIG_ADDR) begin
                    s_axi_bresp <= 2'b00;
                    if (wstrb_q[0]) cfg_sig_q <= wdata_q[7:0];
                    if (wstrb_q[1]) cfg_dev_q <= wdata_q[15:8];
                end else begin
                    s_axi_bresp <= 2'b10;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'b00;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= 2'b00;
                case (s_axi_araddr)
                    TCBD_STATUS_ADDR: s_axi_rdata <= {29'h0, state_q};
                    TCBD_ACTION_ADDR: s_axi_rdata <= {16'h0, rsel_q, act_q};
                    TCBD_RDATA0_ADDR: s_axi_rdata <= {rd_q[3], rd_q[2], rd_q[1], rd_q[0]};
                    TCBD_RDATA1_ADDR: s_axi_rdata <= {rd_q[7], rd_q[6], rd_q[5], rd_q[4]};
                    TCBD_CONFIG_ADDR: s_axi_rdata <= {16'h0, cfg_dev_q, cfg_sig_q};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= 2'b10;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    sequence accepted_s;
        state_q == TCBD_IDLE && cb_valid && sig_ok && bcnt_ok;
    endsequence

    property poll_first_p;
        @(posedge aclk) disable iff (!aresetn)
        accepted_s ##0 !cb[TCBD_IDX_ACT][TCBD_ACT_NOPOLL] |=> state_q == TCBD_POLL;
    endproperty

    ordinary_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        cb_valid && !sig_ok |=> cb_ordinary && !cb_taskfile) else $error("ordinary");
    sig_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state_q == TCBD_IDLE && !(cb_valid && sig_ok) |=> state_q == TCBD_IDLE
        || $past(state_q) != TCBD_IDLE) else $error("decode ungated");
    poll_first_a: assert property (poll_first_p) else $error("no poll");
    bad_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state_q == TCBD_IDLE && cb_valid && sig_ok && !bcnt_ok |=> cmd_fail) else $error("count");
    poll_exit_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state_q == TCBD_POLL && tf_ack && tf_rdata[TCBD_BSY_BIT] |=> state_q == TCBD_POLL)
        else $error("left poll busy");
    ascend_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state_q == TCBD_ACCESS && $rose(tf_req) && $past(state_q) == TCBD_ACCESS
        |-> tf_reg >= $past(idx_q)) else $error("order");
    read_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
        act_q[TCBD_ACT_RDONLY] |-> !xfer_start) else $error("xfer");
    write_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
        state_q == TCBD_ACCESS && tf_req && act_q[TCBD_ACT_RDONLY] |-> !tf_write)
        else $error("wrote on read");
    udma_pick_a: assert property (@(posedge aclk) disable iff (!aresetn)
        accepted_s |=> xfer_udma == $past(cb[TCBD_IDX_ACT][TCBD_ACT_UDMA])) else $error("udma");
endmodule // tcbd_decoder
`default_nettype wire

// File: sim/tcbd_seq_model.sv
// Behavioural taskfile sequencer and transfer engine on the decoder's far side.
// Assumes the decoder's aclk; register contents are fixed per index except status bit 7, which reports busy.
`timescale 1ns/1ps
`default_nettype none
module tcbd_seq_model (
    input  wire logic       aclk,
    input  wire logic       tf_req,
    input  wire logic [2:0] tf_reg,
    input  wire logic       xfer_start,
    output logic            tf_ack,
    output logic [7:0]      tf_rdata,
    output logic            xfer_done_async
);
    logic [1:0] wait_q = 2'h0;
    logic [3:0] run_q  = 4'hf;
    logic       busy_q = 1'b0;
    logic [3:0] idle_q = 4'h0;
    initial tf_ack = 1'b0;
    initial tf_rdata = 8'h00;
    // Wait follows the low two index bits, so prompt and slow answers both occur
    always @(posedge aclk) begin
        tf_ack   <= 1'b0;
        tf_rdata <= ~tf_rdata;  // Data only meaningful beside the ack
        if (tf_req && !tf_ack) begin
            if (wait_q == tf_reg[1:0]) begin
                tf_ack   <= 1'b1;
                tf_rdata <= {busy_q && tf_reg == 3'h7, 7'h30 + {4'h0, tf_reg}};
                wait_q   <= 2'h0;
            end else begin
                wait_q <= wait_q + 2'h1;
            end
        end
    end
    // A long quiet spell makes the next answer busy once, if that answer is a status read
    always @(posedge aclk) begin
        if (tf_req)
            idle_q <= 4'h0;
        else if (idle_q != 4'hf)
            idle_q <= idle_q + 4'h1;
        if (idle_q == 4'he)
            busy_q <= 1'b1;
        else if (tf_ack)
            busy_q <= 1'b0;
    end
    // Done is a short level burst, so a stale level never meets the next start
    always @(posedge aclk) begin
        if (xfer_start)
            run_q <= 4'h0;
        else if (run_q != 4'hf)
            run_q <= run_q + 4'h1;
    end
    assign xfer_done_async = (run_q >= 4'h6) && (run_q <= 4'h9);
endmodule // tcbd_seq_model
`default_nettype wire

// File: sim/taskfile_command_block_decoder_tb.sv
// Self-checking bench for the taskfile command block decoder.
// Assumes tcbd_pkg and the sequencer model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module taskfile_command_block_decoder_tb;
    import tcbd_pkg::*;
    logic         aclk = 0, aresetn = 0, cb_valid = 0, dev_error = 0, chk_on = 0;
    logic         awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0]   awaddr = 0, araddr = 0, sig = 8'hc3;
    logic [31:0]  wdata = 0, rdata;
    logic [127:0] cb_bytes = 0;
    logic         aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, cb_tf, cb_ord, tf_req, tf_write;
    logic         tf_ack, xs, xu, xi, xh, done_a, c_pass, c_fail;
    logic [1:0]   bresp, rresp;
    logic [2:0]   tf_reg;
    logic [7:0]   tf_wdata, tf_rdata;
    logic [33:0]  q_bus[$];
    logic [3:0]   q_ev[$], q_reg[$];
    logic [9:0]   q_sel[$];
    int           n_errors = 0, samples_checked = 0, cyc = 0;
    always #50 aclk = ~aclk;
    tcbd_decoder dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(aw_rdy), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(w_rdy),
        .s_axi_bresp(bresp), .s_axi_bvalid(b_vld), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(ar_rdy),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(r_vld),
        .s_axi_rready(rready), .cb_valid(cb_valid), .cb_bytes(cb_bytes),
        .cb_taskfile(cb_tf), .cb_ordinary(cb_ord), .dev_error(dev_error),
        .phase_error(1'b0), .tf_req(tf_req), .tf_write(tf_write), .tf_reg(tf_reg),
        .tf_wdata(tf_wdata), .tf_ack(tf_ack), .tf_rdata(tf_rdata), .xfer_start(xs),
        .xfer_udma(xu), .xfer_identify(xi), .xfer_halt(xh), .xfer_done_async(done_a),
        .cmd_pass(c_pass), .cmd_fail(c_fail));
    tcbd_seq_model far (.aclk(aclk), .tf_req(tf_req), .tf_reg(tf_reg), .xfer_start(xs),
        .tf_ack(tf_ack), .tf_rdata(tf_rdata), .xfer_done_async(done_a));
    // ---------------------------------------------------------------
    // Checking and bus tasks
    // ---------------------------------------------------------------
    task automatic bad(input string m);
        n_errors++;
        $display("BAD %0t %s", $time, m);
    endtask
    task automatic chk_bus(input logic [33:0] g);
        samples_checked++;
        if (q_bus.size() == 0 || g !== q_bus.pop_front()) bad("bus answer differs");
    endtask
    task automatic chk_ev(input logic [3:0] g);
        samples_checked++;
        if (q_ev.size() == 0 || g !== q_ev.pop_front()) bad("block status differs");
    endtask
    task automatic chk_reg(input logic [3:0] g);
        samples_checked++;
        if (q_reg.size() == 0 || g !== q_reg.pop_front()) bad("register access differs");
    endtask
    task automatic chk_sel(input logic [9:0] g);
        samples_checked++;
        if (q_sel.size() == 0 || g !== q_sel.pop_front()) bad("device select differs");
    endtask
    always @(posedge aclk) begin
        if (r_vld && rready) chk_bus({rresp, rdata});
        if (b_vld && bready) chk_bus({bresp, 32'h0});
        if (cb_tf || cb_ord || c_pass || c_fail) chk_ev({cb_tf, cb_ord, c_pass, c_fail});
        if (chk_on && tf_req && tf_ack) chk_reg({tf_write, tf_reg});
        if (tf_req && tf_ack && tf_write && tf_reg == TCBD_REG_DEVHEAD)
            chk_sel({xu, xi, tf_wdata});
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            print_verdict();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ok_a, ok_w;
        q_bus.push_back({r, 32'h0});
        ok_a = 0;
        ok_w = 0;
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        while (!(ok_a && ok_w)) begin
            @(posedge aclk);
            ok_a |= aw_rdy;
            ok_w |= w_rdy;
            if (aw_rdy) awvalid <= 1'b0;
            if (w_rdy) wvalid <= 1'b0;
        end
        while (!b_vld) @(posedge aclk);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        q_bus.push_back(e);
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do @(posedge aclk); while (!ar_rdy);
        arvalid <= 1'b0;
        while (!r_vld) @(posedge aclk);
        rready <= 1'b0;
    endtask
    task automatic cb(input logic [7:0] s0, s1, act, rs, cnt);
        int n;
        n = 0;
        @(posedge aclk);
        cb_valid <= 1'b1;
        cb_bytes <= {32'h0, 8'he0, 48'h0, cnt, rs, act, s1, s0};
        @(posedge aclk);
        cb_valid <= 1'b0;
        cb_bytes <= ~cb_bytes;
        while (!(c_pass || c_fail || cb_ord) && n < 500) begin
            @(posedge aclk);
            n++;
        end
        if (n >= 500) bad("no block status");
        repeat (12) @(posedge aclk);
    endtask
    task automatic print_verdict();
        n_errors += q_bus.size() + q_ev.size() + q_reg.size() + q_sel.size();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        logic [7:0]  rs, act, cnt;
        logic [63:0] ex;
        void'($urandom(32'h81091558));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(TCBD_STATUS_ADDR, 34'h0);
        wr(TCBD_CONFIG_ADDR, {16'h0, 8'h20, sig}, 2'b00);
        rd(TCBD_CONFIG_ADDR, {18'h0, 8'h20, sig});
        wr(TCBD_CTRL_ADDR, 32'h1, 2'b10);
        rd(8'h40, {2'b10, 32'h0});
        q_ev = {4'b0100, 4'b0100, 4'b1001, 4'b1001};
        cb(~sig, TCBD_SUBCMD, 8'h05, 8'hff, 8'h01);
        cb(sig, 8'h25, 8'h05, 8'hff, 8'h01);
        cb(sig, TCBD_SUBCMD, 8'h05, 8'h01, 8'h03);
        cb(sig, TCBD_SUBCMD, 8'h05, 8'h01, 8'h81);
        for (int k = 0; k < 2; k++) begin
            rs = 8'($urandom) | 8'(k);
            act = k ? 8'h05 : 8'h01;
            cnt = 8'h01 << ($urandom % 8);
            for (int i = 0; i < 8; i++) begin
                ex[8*i +: 8] = rs[i] ? 8'(8'h30 + i) : 8'h00;
                if (rs[i] && k) q_reg.push_back(4'(i));
            end
            q_ev = {q_ev, 4'b1000, 4'b0010};
            chk_on = k[0];
            cb(sig, TCBD_SUBCMD, act, rs, cnt);
            chk_on = 1'b0;
            rd(TCBD_RDATA0_ADDR, {2'b00, ex[31:0]});
            rd(TCBD_RDATA1_ADDR, {2'b00, ex[63:32]});
            rd(TCBD_ACTION_ADDR, {18'h0, rs, act});
        end
        dev_error <= 1'b1;
        for (int h = 0; h < 4; h++) begin
            q_ev = {q_ev, 4'b1000, (h < 2) ? 4'b0001 : 4'b0010};
            act = 8'h04 | 8'(h << 3) | (h[0] ? 8'h40 : 8'h00);
            act = act | ((h == 3) ? 8'ha2 : 8'h00);
            q_sel.push_back({h[0], h == 3, (h == 3) ? 8'he0 : 8'hf0});
            cb(sig, TCBD_SUBCMD, act, 8'h00, (h == 0) ? 8'h00 : 8'h80);
        end
        dev_error <= 1'b0;
        print_verdict();
    end
endmodule // taskfile_command_block_decoder_tb
`default_nettype wire
